// ==== hdl/pio_line_regs.vh ====
`ifndef PIO_LINE_REGS_VH
`define PIO_LINE_REGS_VH

// Byte offsets of the register window
`define OFS_OWN_SET 8'h00
`define OFS_OWN_CLR 8'h04
`define OFS_OWN_STAT 8'h08
`define OFS_DRV_SET 8'h10
`define OFS_DRV_CLR 8'h14
`define OFS_DRV_STAT 8'h18
`define OFS_DATA_LATCH 8'h38
`define OFS_PIN_LEVEL 8'h3C
`define OFS_IRQ_MASK_SET 8'h40
`define OFS_IRQ_MASK_CLR 8'h44
`define OFS_IRQ_MASK 8'h48
`define OFS_CHANGE_STAT 8'h4C
`define OFS_FUNC_FIRST 8'h70
`define OFS_FUNC_SECOND 8'h74
`define OFS_FUNC_STAT 8'h78
`define OFS_WGATE_SET 8'hA0
`define OFS_WGATE_CLR 8'hA4
`define OFS_WGATE_STAT 8'hA8

// Address decode width, reset values, settle count and line count
`define ADDR_BITS 8
`define ZERO_WORD 32'h00000000
`define ONES_WORD 32'hFFFFFFFF
`define PRIME_CYCLES 2'h3
`define LINE_COUNT 32

`endif

// ==== hdl/parallel_io_line_control.v ====
`include "pio_line_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module parallel_io_line_control #(
    parameter [31:0] LINE_MASK = `ONES_WORD,
    parameter [31:0] PERIPH_MASK = `ONES_WORD,
    parameter [31:0] OWN_RESET = `ONES_WORD
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [31:0] pad_in,
    output reg [31:0] pad_out,
    output reg [31:0] pad_oe_n,
    input wire [31:0] first_func_out,
    input wire [31:0] first_func_oe,
    input wire [31:0] second_func_out,
    input wire [31:0] second_func_oe,
    output reg [31:0] periph_in,
    output reg irq
);

    // Register map, by byte offset within the window:
    //   00 ownership set, 04 ownership clear, 08 ownership status
    //   10 driver set, 14 driver clear, 18 driver status
    //   38 output data latch, 3C pin level
    //   40 interrupt mask set, 44 mask clear, 48 mask status
    //   4C input change status, cleared by writing ones
    //   70 first function select, 74 second function select, 78 status
    //   A0 write gate set, A4 write gate clear, A8 write gate status
    // Any other offset, a misaligned one or a nonzero upper address
    // answers with an error response; a write there changes nothing.
    //
    // Bus timing:
    //   Every transfer gets exactly one wait state. The ready strobe,
    //   the read data and the error flag all leave flops, so the bus
    //   sees no decode path from address to data in the same cycle.
    //   The cost is one extra cycle per access, which a port of this
    //   kind can easily afford.
    //   A write lands at the edge where ready is sampled high.
    //   Read data stands only in that cycle and is zero otherwise.
    //
    // Set and clear pairs:
    //   Each status word but the change status has a set address and a clear address, so
    //   software can change some lines without a read-modify-write.
    //   That matters because an interrupt handler may touch the same
    //   word as the main code; a set/clear write can never undo a
    //   change made by the other party in between.
    //   The function pair is the odd one: its first address clears
    //   the status bit and its second sets it.
    //
    // Unimplemented lines:
    //   LINE_MASK marks the lines that exist. Write data is masked on
    //   entry, so no bit that software writes ever becomes one on an absent line, and
    //   every read path masks again where state could come from a pin.
    //
    // Lines without a peripheral:
    //   PERIPH_MASK marks lines that have a peripheral behind them.
    //   A line without one is always owned by the controller, whatever
    //   software writes to the ownership clear address.
    //
    // Pin levels:
    //   Pads pass three flops. A new level counts only once the second
    //   and third stages agree, which rejects a level that was caught
    //   mid-transition by the first stage.
    //   For a few edges after reset the pin level simply follows the
    //   synchroniser, so it starts at the real line levels, and change
    //   detection stays off until the pipeline is full; otherwise the
    //   zeroes left by reset would show up as false changes.
    //   If the clock stops, every flop keeps its value, so the pin
    //   level keeps showing what the lines were at that moment.
    //
    // Change status and interrupt:
    //   A detected change sets a sticky bit. Writing a one clears it,
    //   but a change in the same cycle as the clear wins, so no event
    //   is ever lost to a badly timed clear.
    //   The interrupt is a registered level, high while any masked-in
    //   status bit is set.
    //
    // Pad steering:
    //   The controller drives a line from its data latch and driver
    //   enable while it owns the line; otherwise the chosen peripheral
    //   function drives it. Pad outputs are registered so that a decode
    //   glitch never reaches a pin. The pad enable is active low.
    //
    // Limitations:
    //   No glitch filter, pull-up or open-drain control here; those
    //   live beside this block. Byte lanes are not supported: every
    //   access is one full word.

    localparam [31:0] FIXED_OWN = LINE_MASK & ~PERIPH_MASK;

    reg [31:0] own_r;
    reg [31:0] drv_r;
    reg [31:0] func_r;
    reg [31:0] wgate_r;
    reg [31:0] latch_r;
    reg [31:0] level_r;
    reg [31:0] change_r;
    reg [31:0] mask_r;
    reg [31:0] sync1_r;
    reg [31:0] sync2_r;
    reg [31:0] sync3_r;
    reg [1:0] prime_r;
    reg primed_r;

    wire [`ADDR_BITS-1:0] addr = paddr[`ADDR_BITS-1:0];
    wire in_range = (paddr[31:`ADDR_BITS] == 24'h000000) & (paddr[1:0] == 2'h0);
    wire xfer = psel & penable & pready;
    wire wr = xfer & pwrite & in_range;
    wire [31:0] wdat = pwdata & LINE_MASK;
    wire [31:0] stable = ~(sync2_r ^ sync3_r);
    wire [31:0] own_view = own_r | FIXED_OWN;

    // Decoded write strobes
    wire wr_own_set = wr & (addr == `OFS_OWN_SET);
    wire wr_own_clr = wr & (addr == `OFS_OWN_CLR);
    wire wr_drv_set = wr & (addr == `OFS_DRV_SET);
    wire wr_drv_clr = wr & (addr == `OFS_DRV_CLR);
    wire wr_latch = wr & (addr == `OFS_DATA_LATCH);
    wire wr_mask_set = wr & (addr == `OFS_IRQ_MASK_SET);
    wire wr_mask_clr = wr & (addr == `OFS_IRQ_MASK_CLR);
    wire wr_change = wr & (addr == `OFS_CHANGE_STAT);
    wire wr_func_a = wr & (addr == `OFS_FUNC_FIRST);
    wire wr_func_b = wr & (addr == `OFS_FUNC_SECOND);
    wire wr_wg_set = wr & (addr == `OFS_WGATE_SET);
    wire wr_wg_clr = wr & (addr == `OFS_WGATE_CLR);

    // Line change seen once the second and third stages agree
    wire [31:0] level_nxt = (level_r & ~stable) | (sync3_r & stable);
    wire [31:0] changed = (level_nxt ^ level_r) & {32{primed_r}} & LINE_MASK;

    // Per-line pad steering; the controller wins whenever it owns the line
    wire [31:0] pad_out_nxt;
    wire [31:0] pad_oe_nxt;
    genvar i;
    generate
        for (i = 0; i < `LINE_COUNT; i = i + 1) begin : g_line
            // Function bit picks which peripheral drives this line
            wire func_out = func_r[i] ? second_func_out[i] : first_func_out[i];
            wire func_oe = func_r[i] ? second_func_oe[i] : first_func_oe[i];
            assign pad_out_nxt[i] = own_view[i] ? latch_r[i] : func_out;
            // An absent line never drives its pad
            assign pad_oe_nxt[i] = LINE_MASK[i] & (own_view[i] ? drv_r[i] : func_oe);
        end
    endgenerate

    reg [31:0] rdata_nxt;
    reg known_nxt;

    // Read mux; an unmapped address answers with an error and zero data
    always @* begin
        rdata_nxt = `ZERO_WORD;
        known_nxt = in_range;
        if (addr == `OFS_OWN_SET || addr == `OFS_OWN_CLR) begin
            rdata_nxt = `ZERO_WORD;
        end else if (addr == `OFS_OWN_STAT) begin
            rdata_nxt = own_view & LINE_MASK;
        end else if (addr == `OFS_DRV_SET || addr == `OFS_DRV_CLR) begin
            rdata_nxt = `ZERO_WORD;
        end else if (addr == `OFS_DRV_STAT) begin
            rdata_nxt = drv_r;
        end else if (addr == `OFS_DATA_LATCH) begin
            rdata_nxt = latch_r;
        end else if (addr == `OFS_PIN_LEVEL) begin
            rdata_nxt = level_r & LINE_MASK;
        end else if (addr == `OFS_IRQ_MASK_SET || addr == `OFS_IRQ_MASK_CLR) begin
            rdata_nxt = `ZERO_WORD;
        end else if (addr == `OFS_IRQ_MASK) begin
            rdata_nxt = mask_r;
        end else if (addr == `OFS_CHANGE_STAT) begin
            rdata_nxt = change_r;
        end else if (addr == `OFS_FUNC_FIRST || addr == `OFS_FUNC_SECOND) begin
            rdata_nxt = `ZERO_WORD;
        end else if (addr == `OFS_FUNC_STAT) begin
            rdata_nxt = func_r;
        end else if (addr == `OFS_WGATE_SET || addr == `OFS_WGATE_CLR) begin
            rdata_nxt = `ZERO_WORD;
        end else if (addr == `OFS_WGATE_STAT) begin
            rdata_nxt = wgate_r;
        end else begin
            known_nxt = 1'b0;
        end
        if (!known_nxt) begin
            rdata_nxt = `ZERO_WORD;
        end
    end

    // APB answer: one wait state so read data and pready both leave flops
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= `ZERO_WORD;
            pslverr <= 1'b0;
        end else if (psel & penable & ~pready) begin
            pready <= 1'b1;
            prdata <= pwrite ? `ZERO_WORD : rdata_nxt;
            pslverr <= ~known_nxt;
        end else begin
            pready <= 1'b0;
            prdata <= `ZERO_WORD;
            pslverr <= 1'b0;
        end
    end

    // Ownership, driver, function and write-gate set/clear pairs
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            own_r <= OWN_RESET & LINE_MASK;
            drv_r <= `ZERO_WORD;
            func_r <= `ZERO_WORD;
            wgate_r <= `ZERO_WORD;
        end else begin
            if (wr_own_set) begin
                own_r <= own_r | wdat;
            end else if (wr_own_clr) begin
                own_r <= own_r & ~(wdat & PERIPH_MASK);
            end
            if (wr_drv_set) begin
                drv_r <= drv_r | wdat;
            end else if (wr_drv_clr) begin
                drv_r <= drv_r & ~wdat;
            end
            if (wr_func_a) begin
                func_r <= func_r & ~wdat;
            end else if (wr_func_b) begin
                func_r <= func_r | wdat;
            end
            if (wr_wg_set) begin
                wgate_r <= wgate_r | wdat;
            end else if (wr_wg_clr) begin
                wgate_r <= wgate_r & ~wdat;
            end
        end
    end

    // Data latch: gated lines take the written bit, the rest hold
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latch_r <= `ZERO_WORD;
        end else if (wr_latch) begin
            latch_r <= (latch_r & ~wgate_r) | (wdat & wgate_r);
        end
    end

    // Three-stage pad synchroniser; the first stage feeds only the second
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= `ZERO_WORD;
            sync2_r <= `ZERO_WORD;
            sync3_r <= `ZERO_WORD;
        end else begin
            sync1_r <= pad_in;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    // Settle time after reset before levels are trusted as real
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prime_r <= 2'h0;
            primed_r <= 1'b0;
        end else if (!primed_r) begin
            prime_r <= prime_r + 2'h1;
            primed_r <= (prime_r == `PRIME_CYCLES);
        end
    end

    // Pin level holds its last sample whenever the clock stops
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_r <= `ZERO_WORD;
        end else if (!primed_r) begin
            level_r <= sync3_r;
        end else begin
            level_r <= level_nxt;
        end
    end

    // Change status: hardware set wins over a write-one clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            change_r <= `ZERO_WORD;
        end else if (wr_change) begin
            change_r <= (change_r & ~wdat) | changed;
        end else begin
            change_r <= change_r | changed;
        end
    end

    // Interrupt mask set and clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_r <= `ZERO_WORD;
        end else if (wr_mask_set) begin
            mask_r <= mask_r | wdat;
        end else if (wr_mask_clr) begin
            mask_r <= mask_r & ~wdat;
        end
    end

    // Pad steering; registered so the pads see no decode glitches
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pad_out <= `ZERO_WORD;
            pad_oe_n <= `ONES_WORD;
            periph_in <= `ZERO_WORD;
            irq <= 1'b0;
        end else begin
            pad_out <= pad_out_nxt;
            pad_oe_n <= ~pad_oe_nxt;
            periph_in <= sync3_r & LINE_MASK;
            // A fresh change raises the line in the same edge as its status bit
            irq <= |((change_r | changed) & mask_r);
        end
    end

endmodule

`default_nettype wire

// ==== testbench/pio_far_side.sv ====
`timescale 1ns/1ps
`default_nettype none
// Pads plus two peripheral functions; only line 8 gets peripheral drive
module pio_far_side (
    input wire logic [31:0] pad_out,
    input wire logic [31:0] pad_oe_n,
    input wire logic [31:0] ext_level,
    output logic [31:0] pad_in,
    output logic [31:0] f1_out,
    output logic [31:0] f1_oe,
    output logic [31:0] f2_out,
    output logic [31:0] f2_oe
);
    // An undriven pad shows the outside level, so a stale drive cannot hide
    assign pad_in = (pad_out & ~pad_oe_n) | (ext_level & pad_oe_n);
    // Opposite levels make the chosen function visible on the pad
    assign f1_out = 32'h00000000;
    assign f1_oe = 32'h00000100;
    assign f2_out = 32'hFFFFFFFF;
    assign f2_oe = 32'h00000100;
endmodule
`default_nettype wire

// ==== testbench/parallel_io_line_control_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module pio_line_checker #(
    parameter [31:0] LINE_MASK = 32'hFFFFFFFF,
    parameter [31:0] PERIPH_MASK = 32'hFFFFFFFF
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire rd_done;
    // Completed read, the only cycle read data may be nonzero
    assign rd_done = pready && !pwrite;
    ready_one_wait_a: assert property (psel && $rose(penable) |-> !pready ##1 pready) else $error("late pready");
    ready_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
    err_ready_a: assert property (pslverr |-> pready && psel && penable) else $error("stray pslverr");
    rdata_idle_a: assert property (!rd_done |-> prdata == 32'h0) else $error("prdata not idle");
    misalign_err_a: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr) else $error("no misalign error");
    unimpl_zero_a: assert property (rd_done |-> (prdata & ~LINE_MASK) == 32'h0) else $error("absent line read 1");
    wo_read_a: assert property (rd_done && paddr[7:0] inside {8'h00, 8'h04, 8'h10, 8'h14} |-> prdata == 32'h0)
        else $error("write-only read nonzero");
    own_fixed_a: assert property (rd_done && paddr[7:0] == 8'h08 |-> &(prdata | PERIPH_MASK | ~LINE_MASK))
        else $error("fixed line not owned");
    cover property (pslverr);
    cover property (rd_done && paddr[7:0] == 8'h08);
    cover property ($rose(irq));
endmodule
bind parallel_io_line_control pio_line_checker #(.LINE_MASK(LINE_MASK), .PERIPH_MASK(PERIPH_MASK)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
`default_nettype wire

// ==== testbench/parallel_io_line_control_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pio_line_regs.vh"
module parallel_io_line_control_test;
    localparam [31:0] LMASK = 32'h7FFFFFFF;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic e;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] ext = 32'h12345678;
    logic [31:0] q;
    wire [31:0] prdata, pad_out, pad_oe_n, pad_in, f1o, f1e, f2o, f2e, pi;
    wire pready, pslverr, irq;
    int fails = 0;
    int n_tests = 0;
    int cyc = 0;
    always #5 pclk = ~pclk;
    // Line 31 absent, line 0 has no peripheral, lines 0-15 owned at reset
    parallel_io_line_control #(.LINE_MASK(LMASK), .PERIPH_MASK(32'hFFFFFFFE), .OWN_RESET(32'h0000FFFF)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe_n(pad_oe_n), .first_func_out(f1o), .first_func_oe(f1e),
        .second_func_out(f2o), .second_func_oe(f2e), .periph_in(pi), .irq(irq));
    pio_far_side u_far (.pad_out(pad_out), .pad_oe_n(pad_oe_n), .ext_level(ext), .pad_in(pad_in),
        .f1_out(f1o), .f1_oe(f1e), .f2_out(f2o), .f2_oe(f2e));
    task finish_test;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // A hung handshake ends the run as a mismatch
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 2000) begin
            fails++;
            finish_test;
        end
    end
    task chk(input string n, input [31:0] x, input [31:0] g);
        n_tests++;
        if (g !== x) begin
            fails++;
            $display("BAD %s exp %h got %h", n, x, g);
        end
    endtask
    // Request held until pready is sampled high; data taken at that edge
    task xfer(input w, input [7:0] a, input [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= {24'h0, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task wr(input [7:0] a, input [31:0] d);
        xfer(1'h1, a, d);
    endtask
    task rdc(input [7:0] a, input [31:0] x);
        xfer(1'h0, a, 32'h0);
        chk($sformatf("reg %h", a), x, q);
    endtask
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'h1;
        rdc(`OFS_OWN_STAT, 32'h0000FFFF);
        rdc(`OFS_DRV_STAT, 32'h0);
        rdc(`OFS_FUNC_STAT, 32'h0);
        rdc(`OFS_WGATE_STAT, 32'h0);
        rdc(`OFS_CHANGE_STAT, 32'h0);
        rdc(`OFS_PIN_LEVEL, ext & LMASK);
        xfer(1'h0, 8'h0C, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, e});
        $display("reset test done");
        wr(`OFS_OWN_CLR, 32'hFFFFFFFF);
        rdc(`OFS_OWN_STAT, 32'h00000001);
        wr(`OFS_OWN_SET, 32'h000000F0);
        wr(`OFS_OWN_CLR, 32'h0);
        rdc(`OFS_OWN_STAT, 32'h000000F1);
        wr(`OFS_DRV_SET, 32'h800000FF);
        wr(`OFS_DRV_CLR, 32'h0000000F);
        rdc(`OFS_DRV_STAT, 32'h000000F0);
        $display("owner and driver test done");
        wr(`OFS_DATA_LATCH, 32'h000000FF);
        rdc(`OFS_DATA_LATCH, 32'h0);
        wr(`OFS_WGATE_SET, 32'h000000FF);
        wr(`OFS_DATA_LATCH, 32'h00000050);
        wr(`OFS_WGATE_CLR, 32'h0000000F);
        rdc(`OFS_WGATE_STAT, 32'h000000F0);
        wr(`OFS_DATA_LATCH, 32'hFFFFFFFF);
        rdc(`OFS_DATA_LATCH, 32'h000000F0);
        chk("driven pads", 32'h000000F0, pad_out & ~pad_oe_n & 32'hFF);
        rdc(`OFS_PIN_LEVEL, (ext | 32'hF0) & LMASK);
        $display("latch test done");
        wr(`OFS_FUNC_SECOND, 32'h00000100);
        rdc(`OFS_FUNC_STAT, 32'h00000100);
        chk("second fn pad", 32'h100, pad_out & ~pad_oe_n & 32'h100);
        wr(`OFS_FUNC_FIRST, 32'h00000100);
        rdc(`OFS_FUNC_STAT, 32'h0);
        chk("first fn pad", 32'h0, (pad_out | pad_oe_n) & 32'h100);
        $display("function test done");
        // Earlier pad activity set change bits; let it settle, then clear all
        repeat (8) @(posedge pclk);
        wr(`OFS_CHANGE_STAT, 32'hFFFFFFFF);
        rdc(`OFS_CHANGE_STAT, 32'h0);
        wr(`OFS_IRQ_MASK_SET, 32'h00000200);
        rdc(`OFS_IRQ_MASK, 32'h00000200);
        chk("irq idle", 32'h0, {31'h0, irq});
        ext[9] <= 1'h0;
        repeat (8) @(posedge pclk);
        chk("irq raised", 32'h1, {31'h0, irq});
        rdc(`OFS_CHANGE_STAT, 32'h00000200);
        wr(`OFS_IRQ_MASK_CLR, 32'h00000200);
        repeat (2) @(posedge pclk);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(`OFS_CHANGE_STAT, 32'h00000200);
        rdc(`OFS_CHANGE_STAT, 32'h0);
        chk("periph in", pad_in & LMASK, pi);
        $display("change test done");
        finish_test;
    end
endmodule
`default_nettype wire
